// >>> rtl/gpio_pins_pkg.sv
// constants and register map for the general-purpose pin block
//
// Contract
// - four-bit port, direction per bit from dir_reg_b.
// - pull-up on each four-bit-port input pin whose pullup_reg_b bit is set, except pins in oscillator use.
// - single bidirectional pin, direction from dir_reg_c.
// - pull-up on the single bidirectional pin when it is an input and pullup_reg_c set.
// - input-only pin shares the reset input and is never driven.
// - eight-bit port, direction per bit from dir_reg_d.
// - pull-up on each eight-bit-port input pin whose pullup_reg_d bit is set.
// - shared pin is active-low reset; always reset at power-up.
// - oscillator-shared nibble pins weakly pulled down during reset.
// - interrupt inputs detect rising, falling or both edges.
// - count/capture input goes to timer as clock or dual capture.
// - capture input triggers only the first capture register.
// - timer outputs drive their nibble pins in control mode.
// - option selects port use or oscillator for upper nibble pins.
// - nibble-port pins 0 and 1 each switch between port and control mode.
`default_nettype none

package gpio_pins_pkg;

  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [11:0] DATA_B_ADDR = 12'h000;
  localparam logic [11:0] DIR_B_ADDR = 12'h004;
  localparam logic [11:0] PULLUP_B_ADDR = 12'h008;
  localparam logic [11:0] CTRL_B_ADDR = 12'h00c;
  localparam logic [11:0] DATA_C_ADDR = 12'h010;
  localparam logic [11:0] DIR_C_ADDR = 12'h014;
  localparam logic [11:0] PULLUP_C_ADDR = 12'h018;
  localparam logic [11:0] DATA_D_ADDR = 12'h020;
  localparam logic [11:0] DIR_D_ADDR = 12'h024;
  localparam logic [11:0] PULLUP_D_ADDR = 12'h028;
  localparam logic [11:0] EDGE_CFG_ADDR = 12'h030;
  localparam logic [11:0] IRQ_FLAG_ADDR = 12'h034;
  localparam logic [11:0] OPTION_ADDR = 12'h038;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  localparam int TMR_IN_BIT = 0;
  localparam int CAP_IN_BIT = 1;
  localparam int OSC_OUT_BIT = 2;
  localparam int OSC_IN_BIT = 3;
  localparam int WIDE_OUT_BIT = 1;
  localparam int NARROW_OUT_BIT = 0;
  localparam int CTRL_CNT_CLK_BIT = 4;
  // a set direction bit means input
  localparam logic [3:0] DIR_IN_NIB = 4'hf;
  localparam logic [7:0] DIR_IN_BYTE = 8'hff;
  // the shared pin comes out of reset as the reset input
  localparam logic [1:0] OPTION_RST = 2'b10;
  localparam logic [3:0] ZERO_NIB = 4'h0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // edge choice per interrupt input
  typedef enum logic [1:0] {
    EDGE_NONE_TYPE = 2'b00,
    EDGE_RISE_TYPE = 2'b01,
    EDGE_FALL_TYPE = 2'b10,
    EDGE_BOTH_TYPE = 2'b11
  } edge_sel_type;

endpackage : gpio_pins_pkg

`default_nettype wire

// >>> rtl/edge_detect.sv
// edge detector for one synchronous input with selectable edge
`default_nettype none

module edge_detect
  import gpio_pins_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // sample and config
  input wire logic level_in,
  input wire logic [1:0] edge_sel,
  // event
  output logic hit
);

  logic prev_reg;
  logic prev_next;
  logic hit_reg;
  logic hit_next;

  always_comb begin
    prev_next = level_in;
    hit_next = 1'b0;
    unique case (edge_sel_type'(edge_sel))
      EDGE_NONE_TYPE: hit_next = 1'b0;
      EDGE_RISE_TYPE: hit_next = level_in & ~prev_reg;
      EDGE_FALL_TYPE: hit_next = ~level_in & prev_reg;
      EDGE_BOTH_TYPE: hit_next = level_in ^ prev_reg;
    endcase
  end

  // prev starts high so a high pin at release is not seen as a rise
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prev_reg <= 1'b1;
      hit_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      hit_reg <= hit_next;
    end
  end

  assign hit = hit_reg;

endmodule : edge_detect

`default_nettype wire

// >>> rtl/gpio_pins.sv
// pin logic of the four-bit, two-pin and eight-bit ports with apb access
`default_nettype none

module gpio_pins
  import gpio_pins_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // four-bit port pins
  input wire logic [3:0] nibble_port_pins_in,
  output logic [3:0] nibble_port_pins_out,
  output logic [3:0] nibble_port_pins_oe_n,
  output logic [3:0] nibble_pullup_en,
  output logic [3:0] nibble_pulldown_en,
  // single bidirectional pin and input-only reset pin
  input wire logic single_bidir_pin_in,
  output logic single_bidir_pin_out,
  output logic single_bidir_pin_oe_n,
  output logic single_pullup_en,
  input wire logic input_only_pin,
  // eight-bit port pins
  input wire logic [7:0] byte_port_pins_in,
  output logic [7:0] byte_port_pins_out,
  output logic [7:0] byte_port_pins_oe_n,
  output logic [7:0] byte_pullup_en,
  // timer side
  input wire logic wide_timer_out,
  input wire logic narrow_timer_out,
  output logic timer_count_clk,
  output logic capture_first_trig,
  output logic capture_second_trig,
  // interrupt and clock side
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic sys_reset_req_n,
  output logic osc_sel,
  output logic osc_in_pin
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [3:0] data_b_reg, data_b_next;
  logic [3:0] dir_reg_b, dir_b_next;
  logic [3:0] pullup_reg_b, pullup_b_next;
  logic [4:0] ctrl_b_reg, ctrl_b_next;
  logic data_c_reg, data_c_next;
  logic dir_reg_c, dir_c_next;
  logic pullup_reg_c, pullup_c_next;
  logic [7:0] data_d_reg, data_d_next;
  logic [7:0] dir_reg_d, dir_d_next;
  logic [7:0] pullup_reg_d, pullup_d_next;
  logic [3:0] edge_cfg_reg, edge_cfg_next;
  logic [1:0] irq_flag_reg, irq_flag_next;
  logic [1:0] option_reg, option_next;
  logic [31:0] prdata_next;
  logic pready_next;
  logic pslverr_next;
  logic setup;
  logic wr_en;
  logic hit_a;
  logic hit_b;
  logic [3:0] nib_rd;
  logic [7:0] byte_rd;
  logic [1:0] irq_set;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready;
  assign irq_set = {hit_b, hit_a};

  // ------------------------------------------------------------
  // read-back mux per bit
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < BYTE_W; gi++) begin : g_rd
      assign byte_rd[gi] = dir_reg_d[gi] ? byte_port_pins_in[gi]
                                         : data_d_reg[gi];
      if (gi < NIB_W) begin : g_nib
        assign nib_rd[gi] = dir_reg_b[gi] ? nibble_port_pins_in[gi]
                                          : data_b_reg[gi];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // apb register next state
  // ------------------------------------------------------------
  // one wait state: answer comes on the second access edge
  always_comb begin
    data_b_next = data_b_reg;
    dir_b_next = dir_reg_b;
    pullup_b_next = pullup_reg_b;
    ctrl_b_next = ctrl_b_reg;
    data_c_next = data_c_reg;
    dir_c_next = dir_reg_c;
    pullup_c_next = pullup_reg_c;
    data_d_next = data_d_reg;
    dir_d_next = dir_reg_d;
    pullup_d_next = pullup_reg_d;
    edge_cfg_next = edge_cfg_reg;
    option_next = option_reg;
    // flag set beats a same-cycle clear
    irq_flag_next = irq_flag_reg;
    prdata_next = prdata;
    pslverr_next = 1'b0;
    pready_next = psel & penable & ~pready;
    if (wr_en) begin
      unique case (paddr)
        DATA_B_ADDR: data_b_next = pwdata[3:0];
        DIR_B_ADDR: dir_b_next = pwdata[3:0];
        PULLUP_B_ADDR: pullup_b_next = pwdata[3:0];
        CTRL_B_ADDR: ctrl_b_next = pwdata[4:0];
        DATA_C_ADDR: data_c_next = pwdata[0];
        DIR_C_ADDR: dir_c_next = pwdata[0];
        PULLUP_C_ADDR: pullup_c_next = pwdata[0];
        DATA_D_ADDR: data_d_next = pwdata[7:0];
        DIR_D_ADDR: dir_d_next = pwdata[7:0];
        PULLUP_D_ADDR: pullup_d_next = pwdata[7:0];
        EDGE_CFG_ADDR: edge_cfg_next = pwdata[3:0];
        IRQ_FLAG_ADDR: irq_flag_next = irq_flag_reg & ~pwdata[1:0];
        OPTION_ADDR: option_next = pwdata[1:0];
        default: pslverr_next = 1'b0;
      endcase
    end
    irq_flag_next = irq_flag_next | irq_set;
    if (psel & penable & ~pready & ~pwrite) begin
      prdata_next = ZERO_WORD;
      unique case (paddr)
        DATA_B_ADDR: prdata_next[3:0] = nib_rd;
        DIR_B_ADDR: prdata_next[3:0] = dir_reg_b;
        PULLUP_B_ADDR: prdata_next[3:0] = pullup_reg_b;
        CTRL_B_ADDR: prdata_next[4:0] = ctrl_b_reg;
        DATA_C_ADDR: prdata_next[1:0] = {input_only_pin,
          dir_reg_c ? single_bidir_pin_in : data_c_reg};
        DIR_C_ADDR: prdata_next[0] = dir_reg_c;
        PULLUP_C_ADDR: prdata_next[0] = pullup_reg_c;
        DATA_D_ADDR: prdata_next[7:0] = byte_rd;
        DIR_D_ADDR: prdata_next[7:0] = dir_reg_d;
        PULLUP_D_ADDR: prdata_next[7:0] = pullup_reg_d;
        EDGE_CFG_ADDR: prdata_next[3:0] = edge_cfg_reg;
        IRQ_FLAG_ADDR: prdata_next[1:0] = irq_flag_reg;
        OPTION_ADDR: prdata_next[1:0] = option_reg;
        default: pslverr_next = 1'b1;
      endcase
    end
    if (psel & penable & ~pready & pwrite) begin
      unique case (paddr)
        DATA_B_ADDR, DIR_B_ADDR, PULLUP_B_ADDR, CTRL_B_ADDR,
        DATA_C_ADDR, DIR_C_ADDR, PULLUP_C_ADDR, DATA_D_ADDR,
        DIR_D_ADDR, PULLUP_D_ADDR, EDGE_CFG_ADDR, IRQ_FLAG_ADDR,
        OPTION_ADDR: pslverr_next = 1'b0;
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      data_b_reg <= ZERO_NIB;
      dir_reg_b <= DIR_IN_NIB;
      pullup_reg_b <= ZERO_NIB;
      ctrl_b_reg <= 5'h00;
      data_c_reg <= 1'b0;
      dir_reg_c <= 1'b1;
      pullup_reg_c <= 1'b0;
      data_d_reg <= ZERO_BYTE;
      dir_reg_d <= DIR_IN_BYTE;
      pullup_reg_d <= ZERO_BYTE;
      edge_cfg_reg <= 4'h0;
      irq_flag_reg <= 2'b00;
      option_reg <= OPTION_RST;
      prdata <= ZERO_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      data_b_reg <= data_b_next;
      dir_reg_b <= dir_b_next;
      pullup_reg_b <= pullup_b_next;
      ctrl_b_reg <= ctrl_b_next;
      data_c_reg <= data_c_next;
      dir_reg_c <= dir_c_next;
      pullup_reg_c <= pullup_c_next;
      data_d_reg <= data_d_next;
      dir_reg_d <= dir_d_next;
      pullup_reg_d <= pullup_d_next;
      edge_cfg_reg <= edge_cfg_next;
      irq_flag_reg <= irq_flag_next;
      option_reg <= option_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // ------------------------------------------------------------
  // edge detection for the two interrupt inputs
  // ------------------------------------------------------------
  edge_detect u_edge_a (
    .mclk(mclk),
    .resetn(resetn),
    .level_in(nibble_port_pins_in[CAP_IN_BIT]),
    .edge_sel(edge_cfg_reg[1:0]),
    .hit(hit_a)
  );

  edge_detect u_edge_b (
    .mclk(mclk),
    .resetn(resetn),
    .level_in(single_bidir_pin_in),
    .edge_sel(edge_cfg_reg[3:2]),
    .hit(hit_b)
  );

  // ------------------------------------------------------------
  // pin drivers; direction bit 1 means input, oe_n low drives
  // ------------------------------------------------------------
  logic [3:0] nib_out_next, nib_oe_n_next, nib_pu_next, nib_pd_next;
  logic [7:0] byte_oe_n_next, byte_pu_next;
  logic osc_on;
  logic in_reset;
  assign osc_on = option_reg[0];
  assign in_reset = ~resetn;

  always_comb begin
    nib_out_next = data_b_reg;
    nib_oe_n_next = dir_reg_b;
    nib_pu_next = pullup_reg_b & dir_reg_b;
    nib_pd_next = ZERO_NIB;
    // a pin driven by a timer must not keep its pull-up
    if (ctrl_b_reg[WIDE_OUT_BIT]) begin
      nib_out_next[WIDE_OUT_BIT] = wide_timer_out;
      nib_oe_n_next[WIDE_OUT_BIT] = 1'b0;
      nib_pu_next[WIDE_OUT_BIT] = 1'b0;
    end
    if (ctrl_b_reg[NARROW_OUT_BIT]) begin
      nib_out_next[NARROW_OUT_BIT] = narrow_timer_out;
      nib_oe_n_next[NARROW_OUT_BIT] = 1'b0;
      nib_pu_next[NARROW_OUT_BIT] = 1'b0;
    end
    if (osc_on) begin
      nib_oe_n_next[OSC_OUT_BIT] = 1'b1;
      nib_oe_n_next[OSC_IN_BIT] = 1'b1;
      nib_pu_next[OSC_OUT_BIT] = 1'b0;
      nib_pu_next[OSC_IN_BIT] = 1'b0;
    end
    byte_oe_n_next = dir_reg_d;
    byte_pu_next = pullup_reg_d & dir_reg_d;
    if (in_reset) begin
      nib_oe_n_next = 4'hf;
      nib_pu_next = ZERO_NIB;
      nib_pd_next[OSC_OUT_BIT] = 1'b1;
      nib_pd_next[OSC_IN_BIT] = 1'b1;
      byte_oe_n_next = 8'hff;
      byte_pu_next = ZERO_BYTE;
    end
  end

  // synchronous reset still drives the pin outputs from flip-flops
  always_ff @(posedge mclk) begin
    nibble_port_pins_out <= nib_out_next;
    nibble_port_pins_oe_n <= nib_oe_n_next;
    nibble_pullup_en <= nib_pu_next;
    nibble_pulldown_en <= nib_pd_next;
    byte_port_pins_out <= data_d_reg;
    byte_port_pins_oe_n <= byte_oe_n_next;
    byte_pullup_en <= byte_pu_next;
    single_bidir_pin_out <= data_c_reg;
    single_bidir_pin_oe_n <= in_reset | dir_reg_c;
    single_pullup_en <= ~in_reset & pullup_reg_c & dir_reg_c;
    // input_only_pin has no driver at all
    // reset function is on after power-up; clearing option bit 1 turns it off
    sys_reset_req_n <= in_reset | ~option_reg[1]
      | input_only_pin;
    osc_sel <= ~in_reset & osc_on;
    osc_in_pin <= nibble_port_pins_in[OSC_IN_BIT];
    timer_count_clk <= ctrl_b_reg[CTRL_CNT_CLK_BIT]
      & nibble_port_pins_in[TMR_IN_BIT];
    capture_second_trig <= ~in_reset & ~ctrl_b_reg[CTRL_CNT_CLK_BIT]
      & nibble_port_pins_in[TMR_IN_BIT];
    capture_first_trig <= ~in_reset & ((~ctrl_b_reg[CTRL_CNT_CLK_BIT]
      & nibble_port_pins_in[TMR_IN_BIT])
      | nibble_port_pins_in[CAP_IN_BIT]);
    ext_irq_a <= ~in_reset & irq_flag_reg[0];
    ext_irq_b <= ~in_reset & irq_flag_reg[1];
  end

endmodule : gpio_pins

`default_nettype wire

// >>> dv/board_model.sv
// board-side model of one group of port pins with weak external levels
`default_nettype none

module board_model #(
  parameter int W = 8
) (
  // clock
  input wire logic mclk,
  // what the device does to the pins
  input wire logic [W-1:0] drv_val,
  input wire logic [W-1:0] drv_oe_n,
  input wire logic [W-1:0] pu_en,
  input wire logic [W-1:0] pd_en,
  // board resistors, chosen by the bench
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  // resolved pin level
  output logic [W-1:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] last_reg;
  logic [W-1:0] last_next;

  // a floating pin toggles so that no stale level can pass for a real one
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!drv_oe_n[i]) level[i] = drv_val[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pu_en[i]) level[i] = 1'b1;
      else if (pd_en[i]) level[i] = 1'b0;
      else level[i] = ~last_reg[i];
    end
    last_next = level;
  end

  always_ff @(posedge mclk) begin
    last_reg <= last_next;
  end
endmodule : board_model

`default_nettype wire

// >>> dv/gpio_pins_properties.sv
// timing checks on the ports of the pin block
`default_nettype none

module gpio_pins_properties
  import gpio_pins_pkg::*;
(
  // clock, reset and bus handshake
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [3:0] nibble_port_pins_in,
  input wire logic [3:0] nibble_port_pins_oe_n,
  input wire logic [3:0] nibble_pullup_en,
  input wire logic [3:0] nibble_pulldown_en,
  input wire logic single_bidir_pin_oe_n,
  input wire logic single_pullup_en,
  input wire logic [7:0] byte_port_pins_oe_n,
  input wire logic [7:0] byte_pullup_en,
  input wire logic input_only_pin,
  // routed functions
  input wire logic timer_count_clk,
  input wire logic capture_first_trig,
  input wire logic capture_second_trig,
  input wire logic sys_reset_req_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking

  sequence s_access;
    psel && penable && !pready;
  endsequence
  property p_ready_follows;
    disable iff (!resetn) s_access |=> pready;
  endproperty
  property p_err_with_ready;
    disable iff (!resetn) pslverr |-> pready;
  endproperty
  property p_reset_inputs;
    !resetn |=> (&nibble_port_pins_oe_n) && single_bidir_pin_oe_n
      && (&byte_port_pins_oe_n) && nibble_pullup_en == 4'h0
      && !single_pullup_en && byte_pullup_en == 8'h00;
  endproperty
  property p_reset_pulldown;
    !resetn |=> nibble_pulldown_en[3:2] == 2'b11;
  endproperty
  property p_pulldown_off;
    resetn [*2] |-> nibble_pulldown_en[3:2] == 2'b00;
  endproperty
  property p_pull_nibble;
    disable iff (!resetn) (nibble_pullup_en & ~nibble_port_pins_oe_n) == 4'h0;
  endproperty
  property p_pull_single;
    disable iff (!resetn) !(single_pullup_en && !single_bidir_pin_oe_n);
  endproperty
  property p_pull_byte;
    disable iff (!resetn) (byte_pullup_en & ~byte_port_pins_oe_n) == 8'h00;
  endproperty
  property p_count_clk;
    disable iff (!resetn) timer_count_clk
      |-> !capture_second_trig && $past(nibble_port_pins_in[TMR_IN_BIT]);
  endproperty
  property p_capture_first;
    disable iff (!resetn) capture_first_trig |-> $past(
      nibble_port_pins_in[TMR_IN_BIT] | nibble_port_pins_in[CAP_IN_BIT]);
  endproperty
  property p_reset_pin;
    disable iff (!resetn) !sys_reset_req_n |-> $past(!input_only_pin);
  endproperty

  a_ready_follows: assert property (p_ready_follows)
    else $error("pready missing after access phase");
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr without pready");
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("pin not input or pull-up on during reset");
  a_reset_pulldown: assert property (p_reset_pulldown)
    else $error("oscillator pins not pulled down in reset");
  a_pulldown_off: assert property (p_pulldown_off)
    else $error("pull-down kept after reset");
  a_pull_nibble: assert property (p_pull_nibble)
    else $error("pull-up on a driven nibble pin");
  a_pull_single: assert property (p_pull_single)
    else $error("pull-up on the driven single pin");
  a_pull_byte: assert property (p_pull_byte)
    else $error("pull-up on a driven byte pin");
  a_count_clk: assert property (p_count_clk)
    else $error("count clock not from timer input");
  a_capture_first: assert property (p_capture_first)
    else $error("first capture trigger without cause");
  a_reset_pin: assert property (p_reset_pin)
    else $error("reset request without low reset pin");
endmodule : gpio_pins_properties

bind gpio_pins gpio_pins_properties u_props (.mclk, .resetn, .psel,
  .penable, .pready, .pslverr, .nibble_port_pins_in, .nibble_port_pins_oe_n,
  .nibble_pullup_en, .nibble_pulldown_en, .single_bidir_pin_oe_n,
  .single_pullup_en, .byte_port_pins_oe_n, .byte_pullup_en, .input_only_pin,
  .timer_count_clk, .capture_first_trig, .capture_second_trig,
  .sys_reset_req_n);

`default_nettype wire

// >>> dv/general_io_port_pins_bench.sv
// self-checking bench for the pin block
`default_nettype none

module general_io_port_pins_bench
  import gpio_pins_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] nibble_port_pins_in, nibble_port_pins_out;
  logic [3:0] nibble_port_pins_oe_n, nibble_pullup_en, nibble_pulldown_en;
  logic single_bidir_pin_in, single_bidir_pin_out, single_bidir_pin_oe_n;
  logic single_pullup_en, input_only_pin, wide_timer_out, narrow_timer_out;
  logic [7:0] byte_port_pins_in, byte_port_pins_out;
  logic [7:0] byte_port_pins_oe_n, byte_pullup_en;
  logic timer_count_clk, capture_first_trig, capture_second_trig;
  logic ext_irq_a, ext_irq_b, sys_reset_req_n, osc_sel, osc_in_pin;
  logic [15:0] ext_val, ext_en, all_out, all_oe, all_pu;
  int errors, n_tests, cyc;

  assign all_out = {byte_port_pins_out, 3'b000, single_bidir_pin_out,
    nibble_port_pins_out};
  assign all_oe = {byte_port_pins_oe_n, 3'b000, single_bidir_pin_oe_n,
    nibble_port_pins_oe_n};
  assign all_pu = {byte_pullup_en, 3'b000, single_pullup_en,
    nibble_pullup_en};

  gpio_pins DUT (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .nibble_port_pins_in, .nibble_port_pins_out,
    .nibble_port_pins_oe_n, .nibble_pullup_en, .nibble_pulldown_en,
    .single_bidir_pin_in, .single_bidir_pin_out, .single_bidir_pin_oe_n,
    .single_pullup_en, .input_only_pin, .byte_port_pins_in,
    .byte_port_pins_out, .byte_port_pins_oe_n, .byte_pullup_en,
    .wide_timer_out, .narrow_timer_out, .timer_count_clk,
    .capture_first_trig, .capture_second_trig, .ext_irq_a, .ext_irq_b,
    .sys_reset_req_n, .osc_sel, .osc_in_pin);
  board_model #(.W(4)) board_b (.mclk, .drv_val(nibble_port_pins_out),
    .drv_oe_n(nibble_port_pins_oe_n), .pu_en(nibble_pullup_en),
    .pd_en(nibble_pulldown_en), .ext_val(ext_val[3:0]),
    .ext_en(ext_en[3:0]), .level(nibble_port_pins_in));
  board_model #(.W(1)) board_c (.mclk, .drv_val(single_bidir_pin_out),
    .drv_oe_n(single_bidir_pin_oe_n), .pu_en(single_pullup_en),
    .pd_en(1'b0), .ext_val(ext_val[4]), .ext_en(ext_en[4]),
    .level(single_bidir_pin_in));
  board_model #(.W(8)) board_d (.mclk, .drv_val(byte_port_pins_out),
    .drv_oe_n(byte_port_pins_oe_n), .pu_en(byte_pullup_en),
    .pd_en(8'h00), .ext_val(ext_val[15:8]), .ext_en(ext_en[15:8]),
    .level(byte_port_pins_in));

  // ------------------------------------------------------------
  // bus cycles and reporting
  // ------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // pin outputs launched by the write are seen one edge later
    repeat (2) @(posedge mclk);
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task rd(input logic [11:0] a, output logic [31:0] r);
    apb(1'b0, a, ZERO_WORD, r);
  endtask : rd
  task check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task results;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    logic [31:0] r;
    check("pulldown", 32'(nibble_pulldown_en), 32'h0000_000c);
    check("oe_n", 32'(all_oe), 32'h0000_ff1f);
    check("pullup", 32'(all_pu), ZERO_WORD);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(DIR_D_ADDR, r);
    check("dir", r, 32'(DIR_IN_BYTE));
    check("pulldown", 32'(nibble_pulldown_en), ZERO_WORD);
    rd(OPTION_ADDR, r);
    check("option", r, 32'(OPTION_RST));
    $display("test reset done");
  endtask : t_reset

  task t_port(input int p, input logic [7:0] mask);
    logic [7:0] wm, d, x;
    logic [31:0] r;
    logic [11:0] b;
    int s;
    wm = (p == 0) ? 8'h0f : (p == 1) ? 8'h01 : 8'hff;
    s = p * 4;
    b = 12'(p * 16);
    d = 8'ha5 & wm;
    x = 8'h3c & wm;
    ext_val <= 16'(x) << s;
    wr(b + 12'h004, 32'((DIR_IN_BYTE ^ mask) & wm));
    wr(b, 32'(d));
    check("oe_n", 32'((all_oe >> s) & 16'(wm)),
      32'(~mask & wm));
    check("out", 32'((all_out >> s) & 16'(mask)),
      32'(d & mask));
    rd(b, r);
    check("read", r & 32'(wm), 32'((d & mask) | (x & ~mask)));
    ext_en <= 16'h0000;
    wr(b + 12'h008, 32'(wm));
    check("pullup", 32'((all_pu >> s) & 16'(wm)),
      32'(~mask & wm));
    // let the pulled level reach the input sampler before reading it
    repeat (3) @(posedge mclk);
    rd(b, r);
    check("pulled", r & 32'(wm),
      32'((d & mask) | (~mask & wm)));
    wr(b + 12'h008, ZERO_WORD);
    wr(b + 12'h004, 32'(DIR_IN_BYTE));
    ext_en <= 16'hffff;
    $display("test port %0d done", p);
  endtask : t_port

  task irq_step(input int ch, input logic lvl, input logic exp);
    logic [31:0] r;
    ext_val[ch ? 4 : 1] <= lvl;
    repeat (6) @(posedge mclk);
    rd(IRQ_FLAG_ADDR, r);
    check("irq_flag", 32'(r[ch]), 32'(exp));
    check("irq_line", 32'(ch ? ext_irq_b : ext_irq_a),
      32'(exp));
    wr(IRQ_FLAG_ADDR, 32'h0000_0003);
  endtask : irq_step

  task t_irq;
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 4; m++) begin
        wr(EDGE_CFG_ADDR, ZERO_WORD);
        irq_step(ch, 1'b0, 1'b0);
        wr(EDGE_CFG_ADDR, 32'(m) << (2 * ch));
        irq_step(ch, 1'b1, m[0]);
        irq_step(ch, 1'b0, m[1]);
      end
    end
    $display("test edge interrupts done");
  endtask : t_irq

  task t_timer;
    wr(CTRL_B_ADDR, 32'h0000_0010);
    ext_val[1:0] <= 2'b01;
    repeat (3) @(posedge mclk);
    check("route", 32'({timer_count_clk, capture_first_trig,
      capture_second_trig}), 32'h0000_0004);
    wr(CTRL_B_ADDR, ZERO_WORD);
    check("route", 32'({timer_count_clk, capture_first_trig,
      capture_second_trig}), 32'h0000_0003);
    ext_val[1:0] <= 2'b10;
    repeat (3) @(posedge mclk);
    check("route", 32'({timer_count_clk, capture_first_trig,
      capture_second_trig}), 32'h0000_0002);
    wr(DIR_B_ADDR, 32'(DIR_IN_NIB ^ 4'h3));
    wr(CTRL_B_ADDR, 32'h0000_0003);
    for (int v = 0; v < 4; v++) begin
      narrow_timer_out <= v[0];
      wide_timer_out <= v[1];
      repeat (3) @(posedge mclk);
      check("tmr_out", 32'(nibble_port_pins_out[1:0]),
        32'(v));
    end
    wr(CTRL_B_ADDR, ZERO_WORD);
    wr(DATA_B_ADDR, ZERO_WORD);
    check("port_out", 32'(nibble_port_pins_out[1:0]),
      ZERO_WORD);
    wr(DIR_B_ADDR, 32'(DIR_IN_NIB));
    $display("test timer routing done");
  endtask : t_timer

  task t_option;
    logic [31:0] r;
    wr(OPTION_ADDR, 32'h0000_0001);
    ext_val[3] <= 1'b1;
    repeat (3) @(posedge mclk);
    check("osc", 32'({osc_sel, osc_in_pin}), 32'h0000_0003);
    wr(OPTION_ADDR, 32'h0000_0002);
    input_only_pin <= 1'b0;
    repeat (3) @(posedge mclk);
    check("rst_req", 32'(sys_reset_req_n), ZERO_WORD);
    rd(DATA_C_ADDR, r);
    check("in_only", 32'(r[1]), ZERO_WORD);
    wr(OPTION_ADDR, ZERO_WORD);
    check("rst_req", 32'(sys_reset_req_n), 32'h0000_0001);
    input_only_pin <= 1'b1;
    rd(DATA_C_ADDR, r);
    check("in_only", 32'(r[1]), 32'h0000_0001);
    rd(12'h03c, r);
    check("slverr", 32'(last_err), 32'h0000_0001);
    check("unmapped", r, ZERO_WORD);
    $display("test option and unmapped done");
  endtask : t_option

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      results();
    end
  end

  initial begin
    {psel, penable, pwrite, resetn, wide_timer_out, narrow_timer_out} = '0;
    paddr = '0;
    pwdata = ZERO_WORD;
    input_only_pin = 1'b1;
    ext_val = 16'h0000;
    ext_en = 16'hffff;
    repeat (5) @(posedge mclk);
    t_reset();
    t_port(0, 8'h09);
    t_port(1, 8'h01);
    t_port(1, 8'h00);
    t_port(2, 8'h5a);
    t_irq();
    t_timer();
    t_option();
    results();
  end
endmodule : general_io_port_pins_bench

`default_nettype wire
